// File: rtl/encoder_link.sv
// encoder side of the bidirectional serial position link
//
// Contract
// - four lines: clock pair, bidirectional data pair
// - all bits move with controller clock only
// - newer set accepts older commands plus extras
// - older-only encoder flags error on newer command
// - supported command set readable from memory
// - max clock stored; others limited 2 MHz
// - no position before calculation time elapsed
// - send needed position bits, count readable
// - select code appends one or two words
// - extra words carry warning, mark, busy flags
// - position rises in marked positive direction
// - memory areas write-protectable by manufacturer only
// - square-wave output interpolation 2, 1, 0.5
//
// The address map and the Wishbone slave port were left to the implementer.
`default_nettype none
module encoder_link #(
    parameter int         POS_BITS_MAX = link_pkg::POS_MAX,
    parameter logic [7:0] MAX_CLK_MHZ  = 8'h10
) (
    // clock and reset
    input  wire logic                         ref_clk_i,
    input  wire logic                         rst_b_i,
    // wishbone slave
    input  wire logic                         wb_cyc_i,
    input  wire logic                         wb_stb_i,
    input  wire logic                         wb_we_i,
    input  wire logic [7:0]                   wb_adr_i,
    input  wire logic [3:0]                   wb_sel_i,
    input  wire logic [31:0]                  wb_dat_i,
    output      logic [31:0]                  wb_dat_o,
    output      logic                         wb_ack_o,
    // link pins
    input  wire logic                         link_clk_i,
    input  wire logic                         link_data_i,
    output      logic                         link_data_o,
    output      logic                         link_data_oe_o,
    // sensor core
    input  wire logic [link_pkg::POS_MAX-1:0] position_i,
    input  wire logic                         warning_flag_i,
    input  wire logic                         reference_mark_flag_i,
    // square-wave incremental output
    output      logic                         inc_a_o,
    output      logic                         inc_b_o
);
    localparam int FW = link_pkg::FRAME_W;
    localparam int BW = link_pkg::BIT_W;
    localparam int CW = link_pkg::CNT_W;

    // pin synchronisers
    logic lclk_s1, lclk_s2, lclk_d, din_s1, din_s2;
    logic rise, fall;

    // register file
    logic [31:0] ctrl_reg, ctrl_next;
    logic [3:0]  prot_reg, prot_next;
    logic [7:0]  sel_reg, sel_next;
    logic [31:0] dat_reg, dat_next;
    logic        ack_reg, ack_next;
    logic        wb_wr;

    // link state
    link_pkg::state_t state_reg, state_next;
    logic [BW-1:0] bit_reg, bit_next;
    logic [5:0]    cmd_reg, cmd_next;
    logic [link_pkg::PARAM_W-1:0] rx_reg, rx_next;
    logic [FW-1:0] tx_reg, tx_next;
    logic [CW-1:0] calc_reg, calc_next, idle_reg, idle_next;
    logic [link_pkg::POS_MAX-1:0] pos_reg, pos_next;
    logic dout_reg, dout_next, doe_reg, doe_next;
    logic err_reg, err_next, busy_reg, busy_next;

    // parameter memory
    logic [15:0] mem [0:(1 << link_pkg::MEM_AW)-1];
    logic        mem_we;
    logic [link_pkg::MEM_AW-1:0] mem_wa;
    logic [15:0] mem_wd;

    logic       newer_en;
    logic [5:0] pos_bits;
    logic [5:0] mode_word;
    logic       done_rx;
    logic [FW-1:0] frame;
    logic [BW-1:0] frame_len;

    incr_if inc ();

    function automatic logic [31:0] merge(input logic [31:0] old,
                                          input logic [31:0] nw,
                                          input logic [3:0]  sel);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (sel[i]) begin
                r[i*8 +: 8] = nw[i*8 +: 8];
            end
        end
        return r;
    endfunction

    function automatic logic [15:0] mem_read(input logic [7:0] a,
                                             input logic       nw,
                                             input logic [5:0] pb);
        if (a == link_pkg::INFO_ADDR) begin
            // command set, max clock and position width
            return {nw ? link_pkg::SET_NEWER : link_pkg::SET_OLDER,
                    nw ? MAX_CLK_MHZ : link_pkg::OLD_MAX_MHZ,
                    pb};
        end
        return mem[a[link_pkg::MEM_AW-1:0]];
    endfunction

    function automatic logic [23:0] add_word(input logic [4:0]  a,
                                             input logic [15:0] d,
                                             input logic bsy,
                                             input logic mark,
                                             input logic warn);
        return {bsy, mark, warn, a, d};
    endfunction

    assign newer_en  = ctrl_reg[link_pkg::CTRL_NEWER];
    assign pos_bits  = ctrl_reg[link_pkg::CTRL_POSBITS +: 6];
    assign rise      = lclk_s2 & ~lclk_d;
    assign fall      = ~lclk_s2 & lclk_d;
    assign mode_word = {rx_reg[4:0], din_s2};
    assign wb_wr     = wb_cyc_i & wb_stb_i & wb_we_i & ~ack_reg;

    // register bus
    always_comb begin
        ctrl_next = ctrl_reg;
        prot_next = prot_reg;
        sel_next  = sel_reg;
        ack_next  = wb_cyc_i & wb_stb_i & ~ack_reg;
        dat_next  = '0;
        if (wb_wr) begin
            case (wb_adr_i)
                link_pkg::REG_CTRL:
                    ctrl_next = merge(ctrl_reg, wb_dat_i, wb_sel_i);
                link_pkg::REG_PROTECT:
                    prot_next = wb_sel_i[0] ? wb_dat_i[3:0] : prot_reg;
                link_pkg::REG_SELECT:
                    sel_next = wb_sel_i[0] ? wb_dat_i[7:0] : sel_reg;
                default: ;
            endcase
        end
        if (ack_next && !wb_we_i) begin
            case (wb_adr_i)
                link_pkg::REG_CTRL:    dat_next = ctrl_reg;
                link_pkg::REG_PROTECT: dat_next = {28'h0, prot_reg};
                link_pkg::REG_SELECT:  dat_next = {24'h0, sel_reg};
                link_pkg::REG_STATUS: begin
                    dat_next[link_pkg::STAT_ERR]       = err_reg;
                    dat_next[link_pkg::STAT_BUSY]      = busy_reg;
                    dat_next[link_pkg::STAT_CMD +: 6]  = cmd_reg;
                    dat_next[link_pkg::STAT_ACT]       =
                        (state_reg != link_pkg::ST_IDLE);
                end
                default:               dat_next = '0;
            endcase
        end
        if (done_rx && cmd_reg == link_pkg::CMD_SEL_ADD && newer_en) begin
            sel_next = rx_next[23:16];
        end
    end

    // reply frame of the decoded command
    always_comb begin
        logic [FW-1:0] body;
        logic [1:0]    nadd;
        logic [link_pkg::POS_MAX-1:0] mask;
        body = '0;
        nadd = 2'd0;
        mask = (link_pkg::POS_MAX)'({POS_BITS_MAX{1'b1}})
               >> (link_pkg::POS_MAX - int'(pos_bits));
        frame_len = BW'(2);
        case (cmd_reg)
            link_pkg::CMD_POS, link_pkg::CMD_POS_ADD: begin
                if (cmd_reg == link_pkg::CMD_POS_ADD) begin
                    nadd = sel_reg[link_pkg::SEL_TWO] ? 2'd2 : 2'd1;
                end
                body = FW'(pos_reg & mask);
                body = body << (int'(nadd) * link_pkg::ADD_W);
                if (nadd == 2'd2) begin
                    body[link_pkg::ADD_W +: link_pkg::ADD_W] =
                        add_word(sel_reg[4:0],
                                 mem_read({3'h0, sel_reg[4:0]}, newer_en,
                                          pos_bits),
                                 busy_reg, reference_mark_flag_i,
                                 warning_flag_i);
                    body[link_pkg::ADD_W-1:0] =
                        add_word(link_pkg::STAT_WADDR,
                                 {14'h0, err_reg, newer_en}, busy_reg,
                                 reference_mark_flag_i, warning_flag_i);
                end else if (nadd == 2'd1) begin
                    body[link_pkg::ADD_W-1:0] =
                        add_word(sel_reg[4:0],
                                 mem_read({3'h0, sel_reg[4:0]}, newer_en,
                                          pos_bits),
                                 busy_reg, reference_mark_flag_i,
                                 warning_flag_i);
                end
                frame_len = BW'(2 + int'(pos_bits) +
                                int'(nadd) * link_pkg::ADD_W);
            end
            link_pkg::CMD_MEM_RD, link_pkg::CMD_MEM_WR,
            link_pkg::CMD_SEL_ADD: begin
                body = FW'(add_word(rx_reg[20:16], mem_read(rx_reg[23:16],
                                    newer_en, pos_bits), busy_reg,
                                    reference_mark_flag_i, warning_flag_i));
                frame_len = BW'(2 + link_pkg::ADD_W);
            end
            default: ;
        endcase
        body[int'(frame_len) - 1] = 1'b1;
        body[int'(frame_len) - 2] = err_reg;
        frame = body << (FW - int'(frame_len));
    end

    // link sequencer
    always_comb begin
        state_next = state_reg;
        bit_next   = bit_reg;
        cmd_next   = cmd_reg;
        rx_next    = rx_reg;
        tx_next    = tx_reg;
        calc_next  = calc_reg;
        pos_next   = pos_reg;
        dout_next  = dout_reg;
        doe_next   = doe_reg;
        err_next   = err_reg;
        busy_next  = busy_reg;
        done_rx    = 1'b0;
        mem_we     = 1'b0;
        mem_wa     = rx_reg[8 + link_pkg::MEM_AW +: link_pkg::MEM_AW];
        mem_wd     = {rx_reg[14:0], din_s2};
        idle_next  = (rise || fall || !lclk_s2) ? '0 : idle_reg + CW'(1);
        if (rise && (state_reg == link_pkg::ST_MODE ||
                     state_reg == link_pkg::ST_PARAM)) begin
            rx_next = {rx_reg[link_pkg::PARAM_W-2:0], din_s2};
        end
        case (state_reg)
            link_pkg::ST_IDLE: begin
                doe_next = 1'b0;
                bit_next = '0;
                if (fall) begin
                    state_next = link_pkg::ST_MODE;
                    busy_next  = 1'b0;
                end
            end
            link_pkg::ST_MODE: if (rise) begin
                bit_next = bit_reg + BW'(1);
                if (bit_reg == BW'(link_pkg::MODE_W - 1)) begin
                    cmd_next = mode_word;
                    pos_next = position_i;
                    bit_next = '0;
                    if (link_pkg::is_newer(mode_word) && !newer_en) begin
                        err_next   = 1'b1;
                        cmd_next   = '0;
                        state_next = link_pkg::ST_CALC;
                    end else if (link_pkg::param_len(mode_word) != '0) begin
                        state_next = link_pkg::ST_PARAM;
                    end else begin
                        if (mode_word == link_pkg::CMD_ERR_RST) begin
                            err_next = 1'b0;
                        end
                        state_next = link_pkg::ST_CALC;
                    end
                    calc_next = '0;
                end
            end
            link_pkg::ST_PARAM: if (rise) begin
                bit_next = bit_reg + BW'(1);
                if (bit_reg == link_pkg::param_len(cmd_reg) - BW'(1)) begin
                    done_rx    = 1'b1;
                    state_next = link_pkg::ST_CALC;
                    if (cmd_reg == link_pkg::CMD_MEM_WR &&
                        rx_reg[22:15] != link_pkg::INFO_ADDR &&
                        !prot_reg[rx_reg[15 + link_pkg::AREA_LSB +: 2]]) begin
                        mem_we    = 1'b1;
                        mem_wa    = rx_reg[15 +: link_pkg::MEM_AW];
                        busy_next = 1'b1;
                    end
                    if (cmd_reg == link_pkg::CMD_MEM_RD ||
                        cmd_reg == link_pkg::CMD_SEL_ADD) begin
                        rx_next = {rx_reg[6:0], din_s2, 16'h0000};
                    end
                end
            end
            link_pkg::ST_CALC: begin
                doe_next  = 1'b1;
                dout_next = 1'b0;
                calc_next = calc_reg + CW'(1);
                if (calc_reg >= CW'(link_pkg::TCAL_CYC - 1)) begin
                    tx_next    = frame;
                    bit_next   = frame_len;
                    state_next = link_pkg::ST_SEND;
                end
            end
            link_pkg::ST_SEND: if (fall) begin
                if (bit_reg == '0) begin
                    doe_next   = 1'b0;
                    state_next = link_pkg::ST_WAIT;
                end else begin
                    dout_next = tx_reg[FW-1];
                    tx_next   = tx_reg << 1;
                    bit_next  = bit_reg - BW'(1);
                end
            end
            link_pkg::ST_WAIT:  doe_next = 1'b0;
            default:            state_next = link_pkg::ST_IDLE;
        endcase
        if (wb_wr && wb_adr_i == link_pkg::REG_STATUS && wb_sel_i[0] &&
            wb_dat_i[link_pkg::STAT_ERR] && state_next == state_reg &&
            !(state_reg == link_pkg::ST_MODE && rise)) begin
            err_next = 1'b0;
        end
        if (idle_reg >= CW'(link_pkg::IDLE_CYC - 1) && !rise && !fall) begin
            state_next = link_pkg::ST_IDLE;
            doe_next   = 1'b0;
        end
    end

    always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            lclk_s1   <= 1'b1;
            lclk_s2   <= 1'b1;
            lclk_d    <= 1'b1;
            din_s1    <= 1'b0;
            din_s2    <= 1'b0;
            ctrl_reg  <= link_pkg::CTRL_RESET;
            prot_reg  <= link_pkg::PROTECT_RESET;
            sel_reg   <= link_pkg::SELECT_RESET;
            dat_reg   <= '0;
            ack_reg   <= 1'b0;
            state_reg <= link_pkg::ST_IDLE;
            bit_reg   <= '0;
            cmd_reg   <= '0;
            rx_reg    <= '0;
            tx_reg    <= '0;
            calc_reg  <= '0;
            idle_reg  <= '0;
            pos_reg   <= '0;
            dout_reg  <= 1'b0;
            doe_reg   <= 1'b0;
            err_reg   <= 1'b0;
            busy_reg  <= 1'b0;
        end else begin
            lclk_s1   <= link_clk_i;
            lclk_s2   <= lclk_s1;
            lclk_d    <= lclk_s2;
            din_s1    <= link_data_i;
            din_s2    <= din_s1;
            ctrl_reg  <= ctrl_next;
            prot_reg  <= prot_next;
            sel_reg   <= sel_next;
            dat_reg   <= dat_next;
            ack_reg   <= ack_next;
            state_reg <= state_next;
            bit_reg   <= bit_next;
            cmd_reg   <= cmd_next;
            rx_reg    <= rx_next;
            tx_reg    <= tx_next;
            calc_reg  <= calc_next;
            idle_reg  <= idle_next;
            pos_reg   <= pos_next;
            dout_reg  <= dout_next;
            doe_reg   <= doe_next;
            err_reg   <= err_next;
            busy_reg  <= busy_next;
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (mem_we) begin
            mem[mem_wa] <= mem_wd;
        end
    end

    assign inc.pos    = position_i;
    assign inc.interp = ctrl_reg[link_pkg::CTRL_INTERP +: 2];

    incr_gen u_incr (
        .ref_clk_i (ref_clk_i),
        .rst_b_i   (rst_b_i),
        .inc       (inc.gen)
    );

    assign wb_dat_o       = dat_reg;
    assign wb_ack_o       = ack_reg;
    assign link_data_o    = dout_reg;
    assign link_data_oe_o = doe_reg;
    assign inc_a_o        = inc.inc_a;
    assign inc_b_o        = inc.inc_b;
endmodule
`default_nettype wire

// File: rtl/incr_gen.sv
// square-wave incremental output with selectable interpolation
`default_nettype none
module incr_gen (
    // clock and reset
    input  wire logic ref_clk_i,
    input  wire logic rst_b_i,
    // position and outputs
    incr_if.gen       inc
);
    localparam int PW = link_pkg::POS_MAX + 1;

    logic [PW-1:0] phase_reg;
    logic [PW-1:0] phase_next;
    logic [PW-1:0] target;
    logic          a_reg;
    logic          a_next;
    logic          b_reg;
    logic          b_next;

    always_comb begin
        case (inc.interp)
            link_pkg::INTERP_X2:   target = {inc.pos, 1'b0};
            link_pkg::INTERP_HALF: target = {2'b00, inc.pos[PW-2:1]};
            default:               target = {1'b0, inc.pos};
        endcase
        // walk one quadrature step per cycle toward the target
        phase_next = phase_reg;
        if (target > phase_reg) begin
            phase_next = phase_reg + PW'(1);
        end else if (target < phase_reg) begin
            phase_next = phase_reg - PW'(1);
        end
        a_next = phase_next[1];
        b_next = phase_next[1] ^ phase_next[0];
    end

    always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            phase_reg <= '0;
            a_reg     <= 1'b0;
            b_reg     <= 1'b0;
        end else begin
            phase_reg <= phase_next;
            a_reg     <= a_next;
            b_reg     <= b_next;
        end
    end

    assign inc.inc_a = a_reg;
    assign inc.inc_b = b_reg;
endmodule
`default_nettype wire

// File: rtl/incr_if.sv
// position and interpolation setting toward the square-wave generator
`default_nettype none
interface incr_if;
    logic [link_pkg::POS_MAX-1:0] pos;
    logic [1:0]                   interp;
    logic                         inc_a;
    logic                         inc_b;
    modport src (output pos, output interp, input inc_a, input inc_b);
    modport gen (input pos, input interp, output inc_a, output inc_b);
endinterface
`default_nettype wire

// File: rtl/link_pkg.sv
// constants, types and decode helpers of the encoder serial link
`default_nettype none
package link_pkg;
    // clock and timing
    localparam int CLK_NS   = 40;
    localparam int TCAL_NS  = 2000;
    localparam int TCAL_CYC = (TCAL_NS + CLK_NS - 1) / CLK_NS;
    localparam int IDLE_NS  = 20000;
    localparam int IDLE_CYC = IDLE_NS / CLK_NS;
    localparam int CNT_W    = 10;

    // frame geometry
    localparam int MODE_W   = 6;
    localparam int PARAM_W  = 24;
    localparam int ADD_W    = 24;
    localparam int POS_MAX  = 40;
    localparam int FRAME_W  = 2 + POS_MAX + 2 * ADD_W;
    localparam int BIT_W    = 7;
    localparam int MEM_AW   = 4;

    // mode commands
    localparam logic [5:0] CMD_POS     = 6'h07;
    localparam logic [5:0] CMD_MEM_RD  = 6'h23;
    localparam logic [5:0] CMD_MEM_WR  = 6'h1c;
    localparam logic [5:0] CMD_ERR_RST = 6'h2a;
    localparam logic [5:0] CMD_POS_ADD = 6'h38;
    localparam logic [5:0] CMD_SEL_ADD = 6'h09;

    // register byte offsets
    localparam logic [7:0] REG_CTRL    = 8'h00;
    localparam logic [7:0] REG_STATUS  = 8'h04;
    localparam logic [7:0] REG_PROTECT = 8'h08;
    localparam logic [7:0] REG_SELECT  = 8'h0c;

    // control fields and reset
    localparam int          CTRL_NEWER     = 0;
    localparam int          CTRL_INTERP    = 1;
    localparam int          CTRL_POSBITS   = 8;
    localparam logic [31:0] CTRL_RESET     = 32'h0000_1801;
    localparam logic [3:0]  PROTECT_RESET  = 4'h0;
    localparam logic [7:0]  SELECT_RESET   = 8'h00;
    localparam int          SEL_TWO        = 7;

    // status fields
    localparam int STAT_ERR  = 0;
    localparam int STAT_BUSY = 1;
    localparam int STAT_CMD  = 2;
    localparam int STAT_ACT  = 8;

    // parameter memory map
    localparam logic [7:0]  INFO_ADDR   = 8'hff;
    localparam int          AREA_LSB    = 6;
    localparam logic [1:0]  SET_OLDER   = 2'h1;
    localparam logic [1:0]  SET_NEWER   = 2'h2;
    localparam logic [7:0]  OLD_MAX_MHZ = 8'h02;
    localparam logic [4:0]  STAT_WADDR  = 5'h1f;

    // interpolation of the square-wave output
    localparam logic [1:0] INTERP_X2   = 2'h0;
    localparam logic [1:0] INTERP_X1   = 2'h1;
    localparam logic [1:0] INTERP_HALF = 2'h2;

    typedef enum logic [2:0] {
        ST_IDLE, ST_MODE, ST_PARAM, ST_CALC, ST_SEND, ST_WAIT
    } state_t;

    function automatic logic is_newer(input logic [5:0] cmd);
        return (cmd == CMD_POS_ADD) || (cmd == CMD_SEL_ADD);
    endfunction

    function automatic logic [BIT_W-1:0] param_len(input logic [5:0] cmd);
        case (cmd)
            CMD_MEM_RD,
            CMD_SEL_ADD: return BIT_W'(8);
            CMD_MEM_WR:  return BIT_W'(PARAM_W);
            default:     return '0;
        endcase
    endfunction
endpackage
`default_nettype wire

// File: tb/ctrl_model.sv
// controller model: link clock, mode bits out, reply bits in
`default_nettype none
module ctrl_model (
    // link pins
    input  wire logic line_i,
    output var  logic clk_o,
    output var  logic data_o
);
    timeunit 1ns;
    timeprecision 1ns;
    initial clk_o = 1'b1;
    initial data_o = 1'b0;
    // one period, sampled late for delay compensation
    task automatic tick(output logic b);
        clk_o = 1'b0;
        data_o = ~data_o;
        #160 clk_o = 1'b1;
        #150 b = line_i;
        #10;
    endtask
    task automatic frame(input logic [29:0] cmd, input int n, input int nrep,
                         output logic [79:0] rep);
        logic b;
        int   i;
        rep = '0;
        #13;
        for (i = 0; i < n; i++) begin
            clk_o = 1'b0;
            data_o = cmd[29-i];
            #160 clk_o = 1'b1;
            #160;
        end
        i = 0;
        do begin
            tick(b);
            i++;
        end while (b !== 1'b1 && i < 200);
        for (i = 0; i < nrep; i++) begin
            tick(b);
            rep = {rep[78:0], b};
        end
        tick(b);
        #21000;
    endtask
endmodule
`default_nettype wire

// File: tb/encoder_link_sva.sv
// assertions on the encoder link top ports
`default_nettype none
module encoder_link_sva (
    // clock and reset
    input wire logic        ref_clk_i,
    input wire logic        rst_b_i,
    // watched ports
    input wire logic        wb_cyc_i,
    input wire logic        wb_stb_i,
    input wire logic        wb_we_i,
    input wire logic [7:0]  wb_adr_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic        wb_ack_o,
    input wire logic        link_clk_i,
    input wire logic        link_data_o,
    input wire logic        link_data_oe_o
);
    logic [7:0] low_reg;
    default clocking @(posedge ref_clk_i); endclocking
    default disable iff (!rst_b_i);
    // cycles the reply held data low
    always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) low_reg <= 8'h00;
        else if (!link_data_oe_o) low_reg <= 8'h00;
        else if (!link_data_o && low_reg != 8'hff) low_reg <= low_reg + 8'h01;
    end
    ack_soon_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=>
        wb_ack_o) else $error("ack late");
    ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack long");
    ack_cause_a: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
        else $error("ack unasked");
    write_zero_a: assert property (wb_ack_o && wb_we_i |-> wb_dat_o == 32'h0)
        else $error("data on write");
    hole_zero_a: assert property (wb_ack_o && wb_adr_i > 8'h0c |->
        wb_dat_o == 32'h0) else $error("hole not zero");
    reset_quiet_a: assert property ($rose(rst_b_i) |->
        !wb_ack_o && !link_data_oe_o) else $error("busy after reset");
    calc_wait_a: assert property (
        $rose(link_data_o) && link_data_oe_o |->
        low_reg >= 8'(link_pkg::TCAL_CYC - 1)) else $error("reply early");
    clk_edge_a: assert property (
        link_data_oe_o && $past(link_data_oe_o) &&
        $changed(link_data_o) |-> !$past(link_clk_i, 2) ||
        !$past(link_clk_i, 3) || !$past(link_clk_i, 4) ||
        !$past(link_clk_i, 5)) else $error("data moved unclocked");
endmodule
bind encoder_link encoder_link_sva encoder_link_sva_i (.ref_clk_i, .rst_b_i,
    .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_dat_o, .wb_ack_o,
    .link_clk_i, .link_data_o, .link_data_oe_o);
`default_nettype wire

// File: tb/encoder_link_tb.sv
// self-checking bench of the encoder link
`default_nettype none
module encoder_link_tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic        ref_clk_i = 1'b0;
    logic        rst_b_i = 1'b0;
    logic        wb_cyc_i = 1'b0;
    logic        wb_we_i = 1'b0;
    logic [7:0]  wb_adr_i = 8'h00;
    logic [31:0] wb_dat_i = 32'h0;
    logic [31:0] wb_dat_o, rd;
    logic        wb_ack_o, clk, cdat, edat, eoe, line, inc_a, inc_b;
    logic [1:0]  qd;
    logic [39:0] pos = 40'h12_3456_789a;
    logic [79:0] rep;
    int          bad_count = 0;
    int          tests_run = 0;
    int          cycles = 0;
    assign line = eoe ? edat : cdat;
    always #20 ref_clk_i = ~ref_clk_i;
    encoder_link #(.MAX_CLK_MHZ(8'h08)) encoder_link_i (.ref_clk_i, .rst_b_i,
        .wb_cyc_i, .wb_stb_i(wb_cyc_i), .wb_we_i, .wb_adr_i, .wb_sel_i(4'hf),
        .wb_dat_i, .wb_dat_o, .wb_ack_o, .link_clk_i(clk), .link_data_i(line),
        .link_data_o(edat), .link_data_oe_o(eoe), .position_i(pos),
        .warning_flag_i(1'b0), .reference_mark_flag_i(1'b1), .inc_a_o(inc_a),
        .inc_b_o(inc_b));
    ctrl_model ctrl_model_i (.line_i(line), .clk_o(clk), .data_o(cdat));
    task automatic wb(input logic we, input logic [7:0] a,
                      input logic [31:0] d);
        @(posedge ref_clk_i);
        wb_cyc_i <= 1'b1;
        wb_we_i <= we;
        wb_adr_i <= a;
        wb_dat_i <= d;
        do @(posedge ref_clk_i); while (wb_ack_o !== 1'b1);
        rd = wb_dat_o;
        wb_cyc_i <= 1'b0;
        @(posedge ref_clk_i);
    endtask
    task automatic fr(input logic [29:0] c, input int n, input int r);
        ctrl_model_i.frame(c, n, r, rep);
    endtask
    task automatic chk(input string n, input logic [79:0] e, g);
        tests_run++;
        if (g !== e) begin
            bad_count++;
            $display("MISMATCH %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic complete_run;
        $display("checks %0d mismatches %0d", tests_run, bad_count);
        if (bad_count == 0 && tests_run > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    always @(posedge ref_clk_i) begin
        cycles++;
        if (cycles == 20000) begin
            bad_count++;
            complete_run();
        end
    end
    initial begin
        repeat (16) @(posedge ref_clk_i);
        rst_b_i <= 1'b1;
        repeat (3) @(posedge ref_clk_i);
        wb(1'b0, link_pkg::REG_CTRL, 32'h0);
        chk("ctrl", 80'(link_pkg::CTRL_RESET), 80'(rd));
        fr({link_pkg::CMD_POS, 24'h0}, 6, 25);
        chk("pos", 80'(24'h56_789a), rep);
        wb(1'b1, link_pkg::REG_CTRL, 32'h0000_1001);
        pos <= pos + 40'h1;
        fr({link_pkg::CMD_POS, 24'h0}, 6, 17);
        chk("pos16", 80'(16'h789b), rep);
        fr({link_pkg::CMD_MEM_RD, link_pkg::INFO_ADDR, 16'h0}, 14, 25);
        chk("info", 80'({4'h2, 5'h1f, link_pkg::SET_NEWER, 8'h08, 6'h10}),
            rep);
        wb(1'b1, link_pkg::REG_CTRL, 32'h0000_1000);
        fr({link_pkg::CMD_POS_ADD, 24'h0}, 6, 1);
        chk("refuse", 80'h1, rep);
        wb(1'b1, link_pkg::REG_STATUS, 32'h1);
        fr({link_pkg::CMD_POS, 24'h0}, 6, 17);
        chk("older", 80'(16'h789b), rep);
        fr({link_pkg::CMD_POS_ADD, 24'h0}, 6, 1);
        fr({link_pkg::CMD_ERR_RST, 24'h0}, 6, 1);
        chk("errrst", 80'h0, rep);
        wb(1'b1, link_pkg::REG_CTRL, 32'h0000_1001);
        fr({link_pkg::CMD_MEM_WR, 8'h01, 16'h5a3c}, 30, 25);
        fr({link_pkg::CMD_SEL_ADD, 8'h81, 16'h0}, 14, 25);
        fr({link_pkg::CMD_POS_ADD, 24'h0}, 6, 65);
        chk("add", 80'({17'h0789b, 3'h2, 5'h01, 16'h5a3c, 3'h2, 5'h1f,
            16'h1}), rep);
        wb(1'b1, link_pkg::REG_PROTECT, 32'h1);
        fr({link_pkg::CMD_MEM_WR, 8'h01, 16'hbeef}, 30, 25);
        fr({link_pkg::CMD_MEM_RD, 8'h01, 16'h0}, 14, 25);
        chk("guard", 80'({3'h2, 5'h01, 16'h5a3c}), 80'(rep[23:0]));
        @(negedge ref_clk_i);
        qd = {inc_a, inc_b};
        @(negedge ref_clk_i);
        chk("quad", 80'({qd[0], ~qd[1]}), 80'({inc_a, inc_b}));
        wb(1'b0, 8'h40, 32'h0);
        chk("hole", 80'h0, 80'(rd));
        complete_run();
    end
endmodule
`default_nettype wire
